// ### verilog/sxe_pkg.sv
package sxe_pkg;

   // ==========================================
   // widths
   localparam int SXE_DW = 8;
   localparam int SXE_AW = 7;
   localparam int SXE_BW = 3;

   // ==========================================
   // operation codes presented by the decoder
   typedef enum logic [2:0] {
      SXE_OP_NONE = 3'h0,
      SXE_OP_SKIP_MEM = 3'h1,
      SXE_OP_LOAD_SKIP = 3'h2,
      SXE_OP_SKIP_BIT = 3'h3,
      SXE_OP_XOR_ACC = 3'h4,
      SXE_OP_XOR_MEM = 3'h5,
      SXE_OP_XOR_IMM = 3'h6
   } sxe_op_e;

   // ==========================================
   // status byte field positions
   localparam int SXE_ST_C = 0;
   localparam int SXE_ST_AC = 1;
   localparam int SXE_ST_Z = 2;
   localparam int SXE_ST_OV = 3;
   localparam int SXE_ST_PD = 4;
   localparam int SXE_ST_TO = 5;
   localparam int SXE_ST_TC1 = 6;
   localparam int SXE_ST_TC2 = 7;

   // ==========================================
   // reset values
   localparam logic [7:0] SXE_ACC_RST = 8'h00;
   localparam logic [7:0] SXE_STATUS_RST = 8'h00;
   localparam logic [7:0] SXE_ZERO_BYTE = 8'h00;

   // ==========================================
   // timing, in machine cycles
   localparam int SXE_CYC_PLAIN = 1;
   localparam int SXE_CYC_SKIP = 2;

endpackage

// ### verilog/sxe_alu_if.sv
`timescale 1ns/1ps
interface sxe_alu_if;
   import sxe_pkg::*;
   sxe_op_e op;
   logic [7:0] acc;
   logic [7:0] mem;
   logic [7:0] imm;
   logic [2:0] bit_sel;
   logic [7:0] result;
   logic zero;
   logic skip;
   logic wr_acc;
   logic wr_mem;
   logic wr_z;

   modport core (
      output op, acc, mem, imm, bit_sel,
      input result, zero, skip, wr_acc, wr_mem, wr_z
   );
   modport alu (
      input op, acc, mem, imm, bit_sel,
      output result, zero, skip, wr_acc, wr_mem, wr_z
   );
endinterface

// ### verilog/sxe_alu.sv
`timescale 1ns/1ps
module sxe_alu
   import sxe_pkg::*;
(
   // operands and results
   sxe_alu_if.alu a
);

   // ==========================================
   // combinational evaluation
   always_comb begin
      a.result = a.mem;
      a.zero = 1'b0;
      a.skip = 1'b0;
      a.wr_acc = 1'b0;
      a.wr_mem = 1'b0;
      a.wr_z = 1'b0;
      case (a.op)
         SXE_OP_SKIP_MEM: begin
            a.skip = (a.mem == SXE_ZERO_BYTE);
         end
         SXE_OP_LOAD_SKIP: begin
            a.result = a.mem;
            a.wr_acc = 1'b1;
            a.skip = (a.mem == SXE_ZERO_BYTE);
         end
         SXE_OP_SKIP_BIT: begin
            a.skip = ~a.mem[a.bit_sel];
         end
         SXE_OP_XOR_ACC: begin
            a.result = a.acc ^ a.mem;
            a.wr_acc = 1'b1;
            a.wr_z = 1'b1;
         end
         SXE_OP_XOR_MEM: begin
            a.result = a.acc ^ a.mem;
            a.wr_mem = 1'b1;
            a.wr_z = 1'b1;
         end
         SXE_OP_XOR_IMM: begin
            a.result = a.acc ^ a.imm;
            a.wr_acc = 1'b1;
            a.wr_z = 1'b1;
         end
         default: begin
            a.result = a.mem;
         end
      endcase
      a.zero = (a.result == SXE_ZERO_BYTE);
   end

endmodule // sxe_alu

// ### verilog/sxe_core.sv
`timescale 1ns/1ps
// Behaviour
// - zero memory byte skips next, two cycles
// - load byte to accumulator, skip if zero
// - selected bit clear skips, else one cycle
// - xor accumulator with memory into accumulator
// - xor memory with accumulator into memory
// - xor accumulator with immediate into accumulator
// - xor updates zero flag, others untouched
module sxe_core
   import sxe_pkg::*;
#(
   parameter int DW = SXE_DW,
   parameter int AW = SXE_AW
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // instruction from decoder
   input wire logic instr_valid,
   output logic instr_ready,
   input wire sxe_op_e instr_op,
   input wire logic [AW-1:0] instr_addr,
   input wire logic [2:0] instr_bit,
   input wire logic [DW-1:0] instr_imm,
   // pipeline control
   output logic skip_discard,
   output logic instr_done,
   // data memory read port, same cycle
   output logic [AW-1:0] dm_raddr,
   input wire logic [DW-1:0] dm_rdata,
   // data memory write port
   output logic dm_we,
   output logic [AW-1:0] dm_waddr,
   output logic [DW-1:0] dm_wdata,
   // architectural state
   output logic [DW-1:0] acc,
   output logic [7:0] status
);

   // ==========================================
   // sequencer states
   typedef enum logic [1:0] {
      SXE_ST_EXEC = 2'b01,
      SXE_ST_DUMMY = 2'b10
   } sxe_state_e;

   sxe_state_e state_r;
   sxe_state_e state_nxt;

   logic [DW-1:0] acc_r;
   logic [DW-1:0] acc_nxt;
   logic [7:0] status_r;
   logic [7:0] status_nxt;

   logic we_r;
   logic we_nxt;
   logic [AW-1:0] waddr_r;
   logic [AW-1:0] waddr_nxt;
   logic [DW-1:0] wdata_r;
   logic [DW-1:0] wdata_nxt;

   logic done_r;
   logic done_nxt;
   logic [1:0] cyc_r;
   logic [1:0] cyc_nxt;
   logic take;
   logic fwd_hit;
   logic [DW-1:0] mem_byte;

   sxe_alu_if alu_bus ();

   // ==========================================
   // operand path
   // the write lands one cycle late, so a read of the same byte
   // in that cycle must see the pending value, not the stale one
   assign fwd_hit = we_r && (waddr_r == instr_addr);
   assign mem_byte = fwd_hit ? wdata_r : dm_rdata;
   assign dm_raddr = instr_addr;

   // during the dummy cycle the prefetched word is swallowed
   assign instr_ready = 1'b1;
   // a word shown in the dummy cycle is the one fetched behind the skip
   assign take = instr_valid && (state_r == SXE_ST_EXEC);
   assign skip_discard = (state_r == SXE_ST_DUMMY);

   assign alu_bus.op = take ? instr_op : SXE_OP_NONE;
   assign alu_bus.acc = acc_r;
   assign alu_bus.mem = mem_byte;
   assign alu_bus.imm = instr_imm;
   assign alu_bus.bit_sel = instr_bit;

   sxe_alu u_alu (
      .a(alu_bus)
   );

   // ==========================================
   // sequencer
   always_comb begin
      state_nxt = state_r;
      done_nxt = 1'b0;
      case (state_r)
         SXE_ST_EXEC: begin
            if (take && alu_bus.skip) begin
               state_nxt = SXE_ST_DUMMY;
            end else begin
               done_nxt = take;
            end
         end
         SXE_ST_DUMMY: begin
            if (cyc_nxt == 2'(SXE_CYC_SKIP)) begin
               state_nxt = SXE_ST_EXEC;
               done_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = SXE_ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r <= SXE_ST_EXEC;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         done_r <= done_nxt;
      end
   end

   // ==========================================
   // skip length counter
   // the dummy stretch is timed against the shared skip length,
   // so a longer refill only moves the constant, not the states
   always_comb begin
      cyc_nxt = cyc_r;
      case (state_r)
         SXE_ST_EXEC: begin
            if (take) begin
               cyc_nxt = 2'(SXE_CYC_PLAIN);
            end
         end
         SXE_ST_DUMMY: begin
            cyc_nxt = 2'(cyc_r + 2'h1);
         end
         default: begin
            cyc_nxt = 2'h0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cyc_r <= 2'h0;
      end else begin
         cyc_r <= cyc_nxt;
      end
   end

   // ==========================================
   // accumulator and status
   always_comb begin
      acc_nxt = acc_r;
      status_nxt = status_r;
      // loads and the two accumulator xor forms write here
      if (alu_bus.wr_acc) begin
         acc_nxt = alu_bus.result;
      end
      // only the zero bit moves; skip ops never assert wr_z
      if (alu_bus.wr_z) begin
         status_nxt[SXE_ST_Z] = alu_bus.zero;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         acc_r <= SXE_ACC_RST;
         status_r <= SXE_STATUS_RST;
      end else begin
         acc_r <= acc_nxt;
         status_r <= status_nxt;
      end
   end

   // ==========================================
   // memory write-back
   always_comb begin
      // address and data hold between writes; the strobe alone qualifies them
      we_nxt = alu_bus.wr_mem;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      if (alu_bus.wr_mem) begin
         waddr_nxt = instr_addr;
         wdata_nxt = alu_bus.result;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         we_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= '0;
      end else begin
         we_r <= we_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
      end
   end

   // ==========================================
   // outputs
   // every data output comes straight from a register
   assign dm_we = we_r;
   assign dm_waddr = waddr_r;
   assign dm_wdata = wdata_r;
   assign acc = acc_r;
   assign status = status_r;
   assign instr_done = done_r;

endmodule // sxe_core

// ### testbench/sxe_dmem.sv
`timescale 1ns/1ps
// ====
// data memory, same-cycle read
module sxe_dmem (
   // clock
   input wire logic mclk,
   // read
   input wire logic [6:0] raddr,
   output logic [7:0] rdata,
   // write
   input wire logic we,
   input wire logic [6:0] waddr,
   input wire logic [7:0] wdata
);
   logic [7:0] mem [128];
   // bypass so the checker sees what the core forwards
   assign rdata = (we && raddr == waddr) ? wdata : mem[raddr];
   always @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
endmodule // sxe_dmem

// ### testbench/sxe_chk_assertions.sv
`timescale 1ns/1ps
// ====
// port checks
module sxe_chk
   import sxe_pkg::*;
(
   // clock, reset
   input wire logic mclk,
   input wire logic rstn,
   // instruction
   input wire logic instr_valid,
   input wire sxe_op_e instr_op,
   input wire logic [6:0] instr_addr,
   input wire logic [7:0] instr_imm,
   input wire logic [2:0] instr_bit,
   // results
   input wire logic skip_discard,
   input wire logic instr_done,
   input wire logic [7:0] dm_rdata,
   input wire logic dm_we,
   input wire logic [6:0] dm_waddr,
   input wire logic [7:0] dm_wdata,
   input wire logic [7:0] acc,
   input wire logic [7:0] status
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic tk;
   assign tk = instr_valid && !skip_discard;
   skip_zero_a: assert property (tk && instr_op == SXE_OP_SKIP_MEM && dm_rdata == 8'h00
      |=> skip_discard ##1 instr_done) else $error("zero skip");
   skip_one_a: assert property (tk && instr_op == SXE_OP_SKIP_MEM && dm_rdata != 8'h00
      |=> !skip_discard && instr_done) else $error("nonzero skip");
   load_skip_a: assert property (tk && instr_op == SXE_OP_LOAD_SKIP
      |=> acc == $past(dm_rdata) && skip_discard == ($past(dm_rdata) == 8'h00))
      else $error("load skip");
   bit_clear_a: assert property (tk && instr_op == SXE_OP_SKIP_BIT && !dm_rdata[instr_bit]
      |=> skip_discard) else $error("bit clear");
   bit_set_a: assert property (tk && instr_op == SXE_OP_SKIP_BIT && dm_rdata[instr_bit]
      |=> !skip_discard && instr_done) else $error("bit set");
   xor_acc_a: assert property (tk && instr_op == SXE_OP_XOR_ACC
      |=> acc == ($past(acc) ^ $past(dm_rdata)) && status[SXE_ST_Z] == (acc == 8'h00))
      else $error("xor acc");
   xor_mem_a: assert property (tk && instr_op == SXE_OP_XOR_MEM |=> dm_we
      && dm_waddr == $past(instr_addr) && dm_wdata == ($past(acc) ^ $past(dm_rdata))
      && $stable(acc)) else $error("xor mem");
   xor_imm_a: assert property (tk && instr_op == SXE_OP_XOR_IMM
      |=> acc == ($past(acc) ^ $past(instr_imm))) else $error("xor imm");
   flag_keep_a: assert property (tk && instr_op inside {SXE_OP_XOR_ACC, SXE_OP_XOR_MEM,
      SXE_OP_XOR_IMM} |=> (status & 8'hfb) == ($past(status) & 8'hfb)) else $error("flags");
   skip_flags_a: assert property (tk && instr_op inside {SXE_OP_SKIP_MEM, SXE_OP_LOAD_SKIP,
      SXE_OP_SKIP_BIT} |=> $stable(status)) else $error("skip flags");
   mem_zero_a: assert property (tk && instr_op == SXE_OP_XOR_MEM
      |=> status[SXE_ST_Z] == (dm_wdata == 8'h00)) else $error("xor mem zero");
   imm_zero_a: assert property (tk && instr_op == SXE_OP_XOR_IMM
      |=> status[SXE_ST_Z] == (acc == 8'h00)) else $error("xor imm zero");
   dummy_drop_a: assert property (skip_discard
      |=> !skip_discard && instr_done && !dm_we && $stable(acc) && $stable(status))
      else $error("dummy drop");
endmodule // sxe_chk
bind sxe_core sxe_chk u_chk (
   .mclk(mclk),
   .rstn(rstn),
   .instr_valid(instr_valid),
   .instr_op(instr_op),
   .instr_addr(instr_addr),
   .instr_imm(instr_imm),
   .instr_bit(instr_bit),
   .skip_discard(skip_discard),
   .instr_done(instr_done),
   .dm_rdata(dm_rdata),
   .dm_we(dm_we),
   .dm_waddr(dm_waddr),
   .dm_wdata(dm_wdata),
   .acc(acc),
   .status(status)
);

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench
   import sxe_pkg::*;
;
   logic mclk, rstn, valid, rdy, skp, done, we;
   sxe_op_e op;
   logic [6:0] addr, ra, wa;
   logic [7:0] imm, rd, wd, acc, status;
   logic [2:0] bsel;
   int failures, comparisons;
   sxe_core dut (.mclk(mclk), .rstn(rstn), .instr_valid(valid), .instr_ready(rdy),
      .instr_op(op), .instr_addr(addr), .instr_bit(bsel), .instr_imm(imm), .skip_discard(skp),
      .instr_done(done), .dm_raddr(ra), .dm_rdata(rd), .dm_we(we), .dm_waddr(wa),
      .dm_wdata(wd), .acc(acc), .status(status));
   sxe_dmem mem (.mclk(mclk), .raddr(ra), .rdata(rd), .we(we), .waddr(wa), .wdata(wd));
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task put(input sxe_op_e o, input logic [6:0] a, input logic [7:0] x);
      @(negedge mclk);
      op = o;
      addr = a;
      bsel = x[2:0];
      imm = x;
      valid = 1'b1;
   endtask
   task idle;
      @(negedge mclk);
      valid = 1'b0;
   endtask
   task t_skip;
      put(SXE_OP_SKIP_MEM, 7'h01, 8'h00);
      put(SXE_OP_XOR_IMM, 7'h00, 8'hff);
      chk("discard", {7'h0, skp}, 8'h01);
      idle;
      chk("done", {7'h0, done}, 8'h01);
      chk("acc", acc, 8'h00);
      put(SXE_OP_SKIP_MEM, 7'h02, 8'h00);
      idle;
      chk("noskip", {6'h0, skp, done}, 8'h01);
      chk("status", status, 8'h00);
      $display("test skip done");
   endtask
   task t_load;
      put(SXE_OP_LOAD_SKIP, 7'h04, 8'h00);
      put(SXE_OP_LOAD_SKIP, 7'h03, 8'h00);
      chk("acc", acc, 8'h3c);
      chk("noskip", {7'h0, skp}, 8'h00);
      idle;
      chk("acc", acc, 8'h00);
      chk("skip", {7'h0, skp}, 8'h01);
      chk("status", status, 8'h00);
      idle;
      $display("test load done");
   endtask
   task t_bit;
      for (int i = 0; i < 8; i++) begin
         put(SXE_OP_SKIP_BIT, 7'h05, 8'(i));
         idle;
         chk("bit", {7'h0, skp}, {7'h0, i == 0});
         idle;
      end
      $display("test bit done");
   endtask
   task t_xor;
      put(SXE_OP_XOR_IMM, 7'h00, 8'h3c);
      put(SXE_OP_XOR_MEM, 7'h06, 8'h00);
      chk("acc", acc, 8'h3c);
      chk("status", status, 8'h00);
      put(SXE_OP_XOR_ACC, 7'h06, 8'h00);
      chk("we", {wa, we}, 8'h0d);
      chk("wdata", wd, 8'h00);
      chk("acc", acc, 8'h3c);
      chk("status", status, 8'h04);
      put(SXE_OP_XOR_IMM, 7'h00, 8'h3c);
      chk("acc", acc, 8'h3c);
      chk("status", status, 8'h00);
      idle;
      chk("acc", acc, 8'h00);
      chk("status", status, 8'h04);
      chk("mem", mem.mem[6], 8'h00);
      $display("test xor done");
   endtask
   task t_reset;
      put(SXE_OP_XOR_IMM, 7'h00, 8'h3c);
      put(SXE_OP_XOR_MEM, 7'h04, 8'h00);
      @(negedge mclk);
      chk("raddr", {1'b0, ra}, 8'h04);
      chk("pend", {wa, we}, 8'h09);
      chk("acc", acc, 8'h3c);
      chk("zflag", status, 8'h04);
      valid = 1'b0;
      rstn = 1'b0;
      repeat (2) @(negedge mclk);
      chk("racc", acc, 8'h00);
      chk("rstat", status, 8'h00);
      chk("rctl", {5'h0, we, skp, done}, 8'h00);
      chk("rmem", mem.mem[4], 8'h3c);
      rstn = 1'b1;
      put(SXE_OP_XOR_IMM, 7'h00, 8'h0c);
      idle;
      chk("acc", acc, 8'h0c);
      chk("status", status, 8'h00);
      $display("test reset done");
   endtask
   task complete_run;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // ====
   // main sequence
   initial begin
      rstn = 1'b0;
      valid = 1'b0;
      op = SXE_OP_NONE;
      addr = 7'h00;
      bsel = 3'h0;
      imm = 8'h00;
      mem.mem[1] = 8'h00;
      mem.mem[2] = 8'h05;
      mem.mem[3] = 8'h00;
      mem.mem[4] = 8'h3c;
      mem.mem[5] = 8'hfe;
      mem.mem[6] = 8'h3c;
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      rstn = 1'b1;
      chk("ready", {7'h0, rdy}, 8'h01);
      t_skip;
      t_load;
      t_bit;
      t_xor;
      t_reset;
      complete_run;
   end
   // about 57 cycles expected
   initial begin
      #20000;
      failures++;
      complete_run;
   end
endmodule // testbench
